/* shared/rdr_pkg.sv */
// Constants, register map and state types of the ranging diagnostic readout
`default_nettype none

package rdr_pkg;

    // ------------------------------------------------------------
    // Register map (7-bit index; bit 7 of the pointer = auto-increment)
    // ------------------------------------------------------------
    localparam logic [6:0] RDR_REG_DIAG = 7'h40;
    localparam logic [6:0] RDR_REG_HEALTH = 7'h48;
    localparam logic [6:0] RDR_REG_CORR_LO = 7'h52;
    localparam logic [6:0] RDR_REG_CORR_HI = 7'h53;
    localparam logic [6:0] RDR_REG_PWR = 7'h65;
    localparam int RDR_PTR_AI_BIT = 7;
    localparam logic [6:0] RDR_DEV_ADDR_DEF = 7'h62;

    // ------------------------------------------------------------
    // Field values and reset values
    // ------------------------------------------------------------
    localparam logic [2:0] RDR_DIAG_EXIT = 3'h0;
    localparam logic [2:0] RDR_DIAG_ENTER = 3'h7;
    localparam logic [7:0] RDR_DIAG_RESET = 8'h00;
    localparam logic [7:0] RDR_PWR_RESET = 8'h80;
    localparam int RDR_PWR_RX_OFF_BIT = 0;
    localparam int RDR_SAMPLE_W = 9;
    localparam logic [7:0] RDR_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // Timing: receiver settle time after it is switched on
    // ------------------------------------------------------------
    localparam int RDR_CLK_KHZ = 25000;
    localparam int RDR_RX_SETTLE_NS = 10000;
    localparam int RDR_RX_SETTLE_CYC_I = (RDR_RX_SETTLE_NS * RDR_CLK_KHZ + 999_999) / 1_000_000;
    localparam logic [15:0] RDR_RX_SETTLE_CYC = 16'(RDR_RX_SETTLE_CYC_I);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        RDR_ST_IDLE = 3'b000,
        RDR_ST_RX = 3'b001,
        RDR_ST_ACK = 3'b010,
        RDR_ST_TX = 3'b011,
        RDR_ST_MACK = 3'b100
    } rdr_state_t;

    typedef enum logic [1:0] {
        RDR_K_ADDR = 2'b00,
        RDR_K_REG = 2'b01,
        RDR_K_DATA = 2'b10
    } rdr_kind_t;

    // Wake-up health flags, bit 4 down to bit 0 of the health register
    typedef struct packed {
        logic ref_in_range;
        logic ref_overflow;
        logic init_acq_done;
        logic dc_cmd_in_range;
        logic dc_reg_ok;
    } rdr_health_t;

    typedef struct packed {
        rdr_state_t st;
        rdr_kind_t kind;
        logic rw;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic [7:0] ptr;
        logic sda_oe;
        logic [7:0] diag;
        logic test;
        logic [7:0] pwr;
        logic [15:0] settle;
        logic settled;
        rdr_health_t health;
        logic [RDR_SAMPLE_W-1:0] buf0;
        logic [RDR_SAMPLE_W-1:0] buf1;
        logic [1:0] bcnt;
        logic cready;
        logic [15:0] idx;
        logic busy;
        logic [15:0] res;
        logic go;
        logic scl;
        logic sda;
    } rdr_regs_t;

endpackage : rdr_pkg

`default_nettype wire

/* rtl/rdr_readout.sv */
// I2C register slave with test-mode correlation readout, health and power
`default_nettype none

module rdr_readout #(
    parameter logic [6:0] DEV_ADDR = rdr_pkg::RDR_DEV_ADDR_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic corr_valid,
    input wire logic [rdr_pkg::RDR_SAMPLE_W-1:0] corr_sample,
    output logic corr_ready,
    input wire rdr_pkg::rdr_health_t health_i,
    output logic rx_off,
    output logic rx_settled,
    output logic test_mode,
    output logic [15:0] rec_index,
    input wire logic meas_start,
    input wire logic meas_done,
    input wire logic [15:0] meas_result,
    output logic meas_go,
    output logic busy,
    output logic [15:0] result_hold
);
    import rdr_pkg::*;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (DEV_ADDR[0] !== 1'b0 && DEV_ADDR[0] !== 1'b1) begin : g_bad_addr
        $error("DEV_ADDR must be a defined 7-bit address");
    end
    // Settle count must fit the 16-bit timer, else it wraps and settles too early
    if (RDR_RX_SETTLE_CYC_I < 1 || RDR_RX_SETTLE_CYC_I > 65535) begin : g_bad_settle
        $error("settle count does not fit the 16-bit timer");
    end

    rdr_regs_t s_ff;
    rdr_regs_t nxt_s;

    // Register read mux; pointer picks the register
    function automatic logic [7:0] read_val(input rdr_regs_t s);
        logic [7:0] v;
        v = RDR_UNMAPPED;
        case (s.ptr[6:0])
            RDR_REG_DIAG: v = s.diag;
            RDR_REG_HEALTH: v = {3'h0, s.health};
            RDR_REG_CORR_LO: v = (s.bcnt != 2'h0) ? s.buf0[7:0] : 8'h00;
            RDR_REG_CORR_HI: v = (s.bcnt != 2'h0) ? {7'h00, s.buf0[8]} : 8'h00;
            RDR_REG_PWR: v = s.pwr;
            default: v = RDR_UNMAPPED;
        endcase
        return v;
    endfunction : read_val

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic rise;
        logic fall;
        logic start;
        logic stop;
        logic push;
        logic pop;
        logic load;
        rise = 1'b0;
        fall = 1'b0;
        start = 1'b0;
        stop = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        load = 1'b0;
        nxt_s = s_ff;
        nxt_s.scl = scl_i;
        nxt_s.sda = sda_i;
        nxt_s.health = health_i;
        nxt_s.go = 1'b0;
        rise = scl_i & ~s_ff.scl;
        fall = ~scl_i & s_ff.scl;
        start = s_ff.scl & scl_i & s_ff.sda & ~sda_i;
        stop = s_ff.scl & scl_i & ~s_ff.sda & sda_i;
        push = corr_valid & s_ff.cready;

        // Bus sequencing; start and stop override any byte in flight
        if (start) begin
            nxt_s.st = RDR_ST_RX;
            nxt_s.kind = RDR_K_ADDR;
            nxt_s.cnt = 4'h0;
            nxt_s.sda_oe = 1'b0;
        end else if (stop) begin
            nxt_s.st = RDR_ST_IDLE;
            nxt_s.sda_oe = 1'b0;
        end else begin
            case (s_ff.st)
                RDR_ST_IDLE: begin
                    nxt_s.sda_oe = 1'b0;
                end
                RDR_ST_RX: begin
                    if (rise) begin
                        nxt_s.sh = {s_ff.sh[6:0], sda_i};
                        nxt_s.cnt = s_ff.cnt + 4'h1;
                    end else if (fall && s_ff.cnt == 4'h8) begin
                        nxt_s.cnt = 4'h0;
                        nxt_s.st = RDR_ST_ACK;
                        nxt_s.sda_oe = 1'b1;
                        case (s_ff.kind)
                            RDR_K_ADDR: begin
                                nxt_s.rw = s_ff.sh[0];
                                if (s_ff.sh[7:1] != DEV_ADDR) begin
                                    nxt_s.st = RDR_ST_IDLE;
                                    nxt_s.sda_oe = 1'b0;
                                end else if (s_ff.sh[0]) begin
                                    load = 1'b1;
                                end else begin
                                    nxt_s.kind = RDR_K_REG;
                                end
                            end
                            RDR_K_REG: begin
                                nxt_s.ptr = s_ff.sh;
                                nxt_s.kind = RDR_K_DATA;
                            end
                            default: begin
                                // Writes to read-only or unmapped places are dropped
                                if (s_ff.ptr[6:0] == RDR_REG_DIAG) begin
                                    nxt_s.diag = s_ff.sh;
                                    if (s_ff.sh[2:0] == RDR_DIAG_EXIT) begin
                                        nxt_s.test = 1'b0;
                                    end else if (s_ff.sh[2:0] == RDR_DIAG_ENTER) begin
                                        nxt_s.test = 1'b1;
                                        nxt_s.idx = 16'h0000;
                                    end
                                end
                                if (s_ff.ptr[6:0] == RDR_REG_PWR) begin
                                    nxt_s.pwr = s_ff.sh;
                                end
                                if (s_ff.ptr[RDR_PTR_AI_BIT]) begin
                                    nxt_s.ptr = {1'b1, s_ff.ptr[6:0] + 7'h01};
                                end
                            end
                        endcase
                    end
                end
                RDR_ST_ACK: begin
                    if (fall) begin
                        if (s_ff.rw) begin
                            nxt_s.st = RDR_ST_TX;
                            nxt_s.sda_oe = ~s_ff.tx[7];
                        end else begin
                            nxt_s.st = RDR_ST_RX;
                            nxt_s.sda_oe = 1'b0;
                        end
                    end
                end
                RDR_ST_TX: begin
                    if (rise) begin
                        nxt_s.cnt = s_ff.cnt + 4'h1;
                    end else if (fall) begin
                        if (s_ff.cnt == 4'h8) begin
                            nxt_s.st = RDR_ST_MACK;
                            nxt_s.sda_oe = 1'b0;
                        end else if (s_ff.cnt == 4'h0) begin
                            nxt_s.sda_oe = ~s_ff.tx[7];
                        end else begin
                            nxt_s.tx = {s_ff.tx[6:0], 1'b0};
                            nxt_s.sda_oe = ~s_ff.tx[6];
                        end
                    end
                end
                RDR_ST_MACK: begin
                    // Host ack asks for the next byte of the same transaction
                    if (rise) begin
                        nxt_s.cnt = 4'h0;
                        if (!sda_i) begin
                            nxt_s.st = RDR_ST_TX;
                            load = 1'b1;
                        end else begin
                            nxt_s.st = RDR_ST_IDLE;
                        end
                    end
                end
                default: begin
                    nxt_s.st = RDR_ST_IDLE;
                    nxt_s.sda_oe = 1'b0;
                end
            endcase
        end

        // Byte fetch; the high byte read consumes the sample
        if (load) begin
            nxt_s.tx = read_val(s_ff);
            if (s_ff.ptr[6:0] == RDR_REG_CORR_HI && s_ff.bcnt != 2'h0) begin
                pop = 1'b1;
                nxt_s.idx = s_ff.idx + 16'h0001;
            end
            if (s_ff.ptr[RDR_PTR_AI_BIT]) begin
                nxt_s.ptr = {1'b1, s_ff.ptr[6:0] + 7'h01};
            end
        end

        // Two-entry sample buffer; head is buf0
        case ({push, pop})
            2'b10: begin
                if (s_ff.bcnt == 2'h0) begin
                    nxt_s.buf0 = corr_sample;
                end else begin
                    nxt_s.buf1 = corr_sample;
                end
                nxt_s.bcnt = s_ff.bcnt + 2'h1;
            end
            2'b01: begin
                nxt_s.buf0 = s_ff.buf1;
                nxt_s.bcnt = s_ff.bcnt - 2'h1;
            end
            2'b11: begin
                nxt_s.buf0 = (s_ff.bcnt == 2'h1) ? corr_sample : s_ff.buf1;
                nxt_s.buf1 = corr_sample;
            end
            default: begin
                nxt_s.bcnt = s_ff.bcnt;
            end
        endcase
        // Leaving test mode drops stale samples so a new record starts clean
        if (!nxt_s.test) begin
            nxt_s.bcnt = 2'h0;
        end
        nxt_s.cready = nxt_s.test && (nxt_s.bcnt != 2'h2);

        // Receiver settle timer restarts while the receiver is off
        if (nxt_s.pwr[RDR_PWR_RX_OFF_BIT]) begin
            nxt_s.settle = RDR_RX_SETTLE_CYC;
        end else if (s_ff.settle != 16'h0000) begin
            nxt_s.settle = s_ff.settle - 16'h0001;
        end
        nxt_s.settled = ~nxt_s.pwr[RDR_PWR_RX_OFF_BIT] && (nxt_s.settle == 16'h0000);

        // Measurement: done clears busy; a start in the same cycle is ignored while busy
        if (meas_done) begin
            nxt_s.busy = 1'b0;
            nxt_s.res = meas_result;
        end
        if (meas_start && s_ff.settled && !s_ff.busy) begin
            nxt_s.busy = 1'b1;
            nxt_s.go = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_ff <= '0;
            s_ff.st <= RDR_ST_IDLE;
            s_ff.kind <= RDR_K_ADDR;
            s_ff.diag <= RDR_DIAG_RESET;
            s_ff.pwr <= RDR_PWR_RESET;
            s_ff.settle <= RDR_RX_SETTLE_CYC;
            s_ff.scl <= 1'b1;
            s_ff.sda <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from the state register, except sda_o which is tied low
    assign sda_o = 1'b0;
    assign sda_oe = s_ff.sda_oe;
    assign corr_ready = s_ff.cready;
    assign rx_off = s_ff.pwr[RDR_PWR_RX_OFF_BIT];
    assign rx_settled = s_ff.settled;
    assign test_mode = s_ff.test;
    assign rec_index = s_ff.idx;
    assign meas_go = s_ff.go;
    assign busy = s_ff.busy;
    assign result_hold = s_ff.res;

endmodule : rdr_readout

`default_nettype wire

/* dv/rdr_readout_assertions.sv */
// Port-level checker for the ranging diagnostic readout
`default_nettype none
module rdr_chk
    import rdr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic corr_ready,
    input wire logic test_mode,
    input wire logic [15:0] rec_index,
    input wire logic rx_off,
    input wire logic rx_settled,
    input wire logic meas_start,
    input wire logic meas_done,
    input wire logic [15:0] meas_result,
    input wire logic meas_go,
    input wire logic busy,
    input wire logic [15:0] result_hold
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] on_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Cycles since receiver switched on; saturates so it never wraps
    always_ff @(posedge clk) begin
        if (!rst_n || rx_off) on_ff <= 16'h0000;
        else if (on_ff != 16'hffff) on_ff <= on_ff + 16'h0001;
    end
    property p_rdy_off; !test_mode && !$past(test_mode) |-> !corr_ready; endproperty
    a_rdy_off: assert property (p_rdy_off) else $error("ready outside test mode");
    property p_step;
        $changed(rec_index) && test_mode && $past(test_mode)
            |-> rec_index == $past(rec_index) + 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("record index jump");
    property p_off; rx_off && $past(rx_off) |-> !rx_settled; endproperty
    a_off: assert property (p_off) else $error("settled while off");
    property p_settle; $rose(rx_settled) |-> on_ff + 16'h0003 >= RDR_RX_SETTLE_CYC; endproperty
    a_settle: assert property (p_settle) else $error("settled too early");
    property p_nogo; !rx_settled |=> !meas_go; endproperty
    a_nogo: assert property (p_nogo) else $error("start before settle");
    property p_go; meas_start && rx_settled && !busy |=> meas_go && busy; endproperty
    a_go: assert property (p_go) else $error("start not taken");
    property p_hold; !meas_done |=> $stable(result_hold); endproperty
    a_hold: assert property (p_hold) else $error("result changed early");
    property p_load;
        meas_done && busy && !meas_start |=> result_hold == $past(meas_result) && !busy;
    endproperty
    a_load: assert property (p_load) else $error("result not loaded");
endmodule : rdr_chk
`default_nettype wire

/* dv/rdr_host.sv */
// I2C host model reaching the readout registers
`default_nettype none
module rdr_host
    import rdr_pkg::*;
(
    input wire logic clk,
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv;
    logic [15:0] sx;
    // Open drain with pull-up: a released line reads high
    assign sda = drv & ~sda_oe;
    initial begin
        drv = 1'b1;
        scl = 1'b1;
    end
    task automatic hc();
        repeat (3) @(negedge clk);
    endtask : hc
    // Start or repeated start; SCL idles high between frames
    task automatic start();
        drv = 1'b1;
        hc();
        scl = 1'b1;
        hc();
        drv = 1'b0;
        hc();
        scl = 1'b0;
    endtask : start
    task automatic stop();
        drv = 1'b0;
        hc();
        scl = 1'b1;
        hc();
        drv = 1'b1;
        hc();
    endtask : stop
    // Eight bits then the acknowledge slot, MSB first
    task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic ak);
        logic [8:0] s;
        s = {d, a};
        for (int i = 8; i >= 0; i--) begin
            drv = s[i];
            hc();
            scl = 1'b1;
            hc();
            s[i] = sda;
            scl = 1'b0;
        end
        q = s[8:1];
        ak = s[0];
    endtask : xb
    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
                      input logic has_d, output logic nak);
        logic [7:0] x;
        logic a0, a1, a2;
        a1 = 1'b0;
        a2 = 1'b0;
        start();
        xb({dev, 1'b0}, 1'b1, x, a0);
        if (!a0) xb(ptr, 1'b1, x, a1);
        if (!a0 && has_d) xb(d, 1'b1, x, a2);
        stop();
        nak = a0 | a1 | a2;
    endtask : wr
    task automatic rd(input logic [7:0] ptr, input int n, output logic [15:0] q);
        logic [7:0] b [2];
        logic ak;
        wr(RDR_DEV_ADDR_DEF, ptr, 8'h00, 1'b0, ak);
        start();
        xb({RDR_DEV_ADDR_DEF, 1'b1}, 1'b1, b[0], ak);
        for (int i = 0; i < n; i++) xb(8'hff, i == n - 1, b[i], ak);
        stop();
        q = (n == 2) ? {b[1], b[0]} : {8'h00, b[0]};
        sx = {b[1][0] ? 8'hff : b[1], b[0]};
    endtask : rd
endmodule : rdr_host
`default_nettype wire

/* dv/rdr_readout_bench.sv */
// Self-checking bench for the ranging diagnostic readout
`default_nettype none
module rdr_readout_bench;
    import rdr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, scl, sda, sda_oe, corr_valid, corr_ready, rx_off, rx_settled, took;
    logic test_mode, meas_start, meas_done, meas_go, busy, nak;
    logic [8:0] corr_sample = 9'h000;
    logic [8:0] cq [$];
    logic [15:0] rec_index, meas_result, result_hold, q;
    rdr_health_t health;
    int err_total, compares, cyc;
    rdr_readout u_dut (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe(sda_oe), .corr_valid(corr_valid), .corr_sample(corr_sample),
        .corr_ready(corr_ready), .health_i(health), .rx_off(rx_off),
        .rx_settled(rx_settled), .test_mode(test_mode), .rec_index(rec_index),
        .meas_start(meas_start), .meas_done(meas_done), .meas_result(meas_result),
        .meas_go(meas_go), .busy(busy), .result_hold(result_hold));
    rdr_host u_host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Correlator side: offers queued samples, holds each until taken
    always @(posedge clk) took <= corr_valid & corr_ready;
    always @(negedge clk) begin
        if (took && cq.size() > 0) void'(cq.pop_front());
        corr_valid = cq.size() > 0;
        corr_sample = corr_valid ? cq[0] : ~corr_sample;
    end
    // Hang guard well beyond the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic put(input logic [7:0] r, input logic [7:0] d);
        u_host.wr(RDR_DEV_ADDR_DEF, r, d, 1'b1, nak);
    endtask : put
    task automatic stop_test();
        $display("err_total %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        u_host.rd(8'h65, 1, q);
        chk(q, 16'h0080);
        u_host.wr(RDR_DEV_ADDR_DEF ^ 7'h01, 8'h40, 8'h07, 1'b1, nak);
        chk(16'({nak, test_mode}), 16'h0002);
        health = 5'b10110;
        put(8'h48, 8'hff);
        u_host.rd(8'h48, 1, q);
        chk(q, 16'h0016);
        health = 5'b01001;
        u_host.rd(8'h48, 1, q);
        chk(q, 16'h0009);
        u_host.rd(8'h70, 1, q);
        chk(q, 16'(RDR_UNMAPPED));
    endtask : t_regs
    task automatic t_power();
        int n;
        put(8'h65, 8'h81);
        chk(16'({rx_off, rx_settled}), 16'h0002);
        meas_start = 1'b1;
        repeat (2) @(negedge clk);
        meas_start = 1'b0;
        chk(16'({meas_go, busy}), 16'h0000);
        put(8'h65, 8'h80);
        n = 0;
        while (!rx_settled && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk(16'(n > RDR_RX_SETTLE_CYC_I - 30 && n <= RDR_RX_SETTLE_CYC_I), 16'h0001);
    endtask : t_power
    task automatic t_test();
        put(8'h40, 8'h05);
        chk(16'(test_mode), 16'h0000);
        put(8'h40, 8'h07);
        chk(16'(test_mode), 16'h0001);
        cq = '{9'h1a5, 9'h034, 9'h0ff};
        repeat (8) @(negedge clk);
        chk(16'({corr_ready, 8'(cq.size())}), 16'h0001);
        put(8'h40, 8'h03);
        chk(16'(test_mode), 16'h0001);
        u_host.rd(8'hd2, 2, q);
        chk(q, 16'h01a5);
        chk(u_host.sx, 16'hffa5);
        chk(rec_index, 16'h0001);
        u_host.rd(8'hd2, 2, q);
        chk(q, 16'h0034);
        u_host.rd(8'hd2, 2, q);
        chk(q, 16'h00ff);
        chk(rec_index, 16'h0003);
        put(8'h40, 8'h00);
        chk(16'({test_mode, corr_ready}), 16'h0000);
    endtask : t_test
    task automatic t_meas();
        int n;
        for (int i = 0; i < 2; i++) begin
            meas_start = 1'b1;
            @(negedge clk);
            meas_start = 1'b0;
            chk(16'({meas_go, busy}), 16'h0003);
            chk(result_hold, i ? 16'h1234 : 16'h0000);
            meas_result = i ? 16'h0abc : 16'h1234;
            repeat (5) @(negedge clk);
            meas_done = 1'b1;
            @(negedge clk);
            meas_done = 1'b0;
            n = 0;
            while (busy && n < 20) begin
                @(negedge clk);
                n++;
            end
            chk(16'({busy, 8'(n)}), 16'h0000);
            chk(result_hold, i ? 16'h0abc : 16'h1234);
        end
    endtask : t_meas
    // Mid-run reset: everything set up by earlier scenarios must return to reset values
    task automatic t_reset();
        put(8'h40, 8'h05);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk(result_hold, 16'h0000);
        chk(rec_index, 16'h0000);
        chk(16'({meas_go, busy, rx_settled, test_mode}), 16'h0000);
        u_host.rd(8'h40, 1, q);
        chk(q, 16'(RDR_DIAG_RESET));
    endtask : t_reset
    initial begin
        rst_n = 1'b0;
        meas_start = 1'b0;
        meas_done = 1'b0;
        meas_result = 16'h0000;
        health = 5'b00000;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk(16'({test_mode, busy, rx_off, corr_ready}), 16'h0000);
        t_regs();
        t_power();
        t_test();
        t_meas();
        t_reset();
        stop_test();
    end
endmodule : rdr_readout_bench
bind rdr_readout rdr_chk u_chk (.clk(clk), .rst_n(rst_n), .corr_ready(corr_ready),
    .test_mode(test_mode), .rec_index(rec_index), .rx_off(rx_off),
    .rx_settled(rx_settled), .meas_start(meas_start), .meas_done(meas_done),
    .meas_result(meas_result), .meas_go(meas_go), .busy(busy), .result_hold(result_hold));
`default_nettype wire
